// ==== fuse_pkg.sv ====
// Shared constants and types for the fuse programming link and its two ends
// Summary of operation
// - One programming cycle burns at most eight bits
// - Five banks of 64 bits, values 1 to 5
// - Blank bits read one; burning only clears
// - Bank E is value 5, bank D is 4
// - Bank E bits 3..0 give upper address nibble
// - Fuse address used only once E4 burned or replaced
// - Address byte: nibble, three zeros, direction bit
// - Host writes lowest bit index to 0xC8
// - Host writes count-1 and bank to 0xC9
// - Host writes aligned bit values to 0xCD
// - Host opens access with 0xFF at 0xEC
// - Host pulses 0xCA high for 500 us
// - Host reload sequence makes device reload fuses
// - Verify sequence reads bank E bits at 0x27
// - Readback mismatch is treated as programming error
// - Exactly one failed bit can be replaced
// - Replaced bit index sits in D[63:55]
// - Host burns replacement index in two cycles
// - Replacement confirmed by reading 0x18 and 0x19
package fuse_pkg;
  localparam int BANK_BITS  = 64;
  localparam int NUM_BANKS  = 5;
  localparam int TOTAL_BITS = BANK_BITS * NUM_BANKS;
  localparam int D_BASE     = 3 * BANK_BITS;
  localparam int E_BASE     = 4 * BANK_BITS;
  localparam int IDX_W      = 9;
  localparam int REPL_LSB   = 55;
  localparam int REPL_MSB   = 63;
  localparam int D_VIEW_LSB = 48;
  localparam int E_VIEW_W   = 5;
  localparam int E_ADDR_EN  = 4;
  localparam int PROG_BITS  = 8;

  localparam logic [7:0] REG_REPL_UPPER = 8'h18;
  localparam logic [7:0] REG_REPL_LOWER = 8'h19;
  localparam logic [7:0] REG_ADDR_BITS  = 8'h27;
  localparam logic [7:0] REG_START      = 8'hC8;
  localparam logic [7:0] REG_CNT_BANK   = 8'hC9;
  localparam logic [7:0] REG_STROBE     = 8'hCA;
  localparam logic [7:0] REG_DATA       = 8'hCD;
  localparam logic [7:0] REG_ACCESS     = 8'hEC;
  localparam logic [7:0] REG_RELOAD     = 8'hEE;
  localparam logic [7:0] REG_PAGE       = 8'hEF;

  localparam logic [7:0] ACCESS_OPEN  = 8'hFF;
  localparam logic [7:0] ACCESS_CLOSE = 8'h7F;
  localparam logic [7:0] PAGE_NORMAL  = 8'h00;
  localparam logic [7:0] PAGE_READ    = 8'h03;
  localparam logic [7:0] RELOAD_PREP  = 8'h40;
  localparam logic [7:0] RELOAD_CMD   = 8'h06;
  localparam logic [7:0] STROBE_ON    = 8'h01;
  localparam logic [7:0] STROBE_OFF   = 8'h00;
  localparam logic [7:0] REG_RST      = 8'h00;

  localparam logic [3:0] BANK_FIRST = 4'h1;
  localparam logic [3:0] BANK_D     = 4'h4;
  localparam logic [3:0] BANK_E     = 4'h5;

  localparam logic [7:0] REPL_LO_START = 8'h37;
  localparam logic [7:0] REPL_LO_CB    = 8'h74;
  localparam logic [7:0] REPL_HI_START = 8'h3F;
  localparam logic [7:0] REPL_HI_CB    = 8'h04;

  localparam logic [3:0] ADDR_DFLT_UPPER = 4'h8;
  localparam logic [3:0] ADDR_WR_LOW     = 4'h0;
  localparam logic [3:0] ADDR_RD_LOW     = 4'h1;
  localparam logic [7:0] ADDR_DFLT_WR    = 8'h80;
  localparam logic [7:0] ADDR_DFLT_RD    = 8'h81;

  localparam int PULSE_US      = 500;
  localparam int CLK_HZ        = 40_000_000;
  localparam int PULSE_CYC_DEF = PULSE_US * (CLK_HZ / 1_000_000);

  // Host command port map
  localparam logic [3:0] H_CMD    = 4'h0;
  localparam logic [3:0] H_START  = 4'h1;
  localparam logic [3:0] H_CB     = 4'h2;
  localparam logic [3:0] H_DATA   = 4'h3;
  localparam logic [3:0] H_EXPECT = 4'h4;
  localparam logic [3:0] H_IDX_LO = 4'h5;
  localparam logic [3:0] H_IDX_HI = 4'h6;
  localparam logic [3:0] H_STATUS = 4'h7;
  localparam logic [3:0] H_RB27   = 4'h8;
  localparam logic [3:0] H_RB18   = 4'h9;
  localparam logic [3:0] H_RB19   = 4'hA;

  typedef enum logic [1:0] {STEP_WR, STEP_RD, STEP_WAIT, STEP_END} step_e;

  typedef struct packed {
    step_e      kind;
    logic [7:0] addr;
    logic [7:0] data;
  } step_s;
endpackage

// ==== fuse_bus_if.sv ====
// Byte register link between the fuse host and the sensor fuse logic
`timescale 1ns/1ps
interface fuse_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd,
                input rdata);
endinterface // fuse_bus_if

// ==== fuse_program_dev.sv ====
// Sensor side: fuse array, program registers, reload and slave address
`timescale 1ns/1ps
module fuse_program_dev
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  fuse_bus_if.dev                         bus,
  input  wire logic [fuse_pkg::IDX_W-1:0] weak_bit_i,
  output logic      [7:0]                 slave_wr_addr_o,
  output logic      [7:0]                 slave_rd_addr_o,
  output logic                            fuse_burn_o
);
  import fuse_pkg::*;

  logic [7:0]            start_reg;
  logic [7:0]            cnt_bank_reg;
  logic [7:0]            strobe_reg;
  logic [7:0]            data_reg;
  logic [7:0]            access_reg;
  logic [7:0]            reload_reg;
  logic [7:0]            page_reg;
  logic [7:0]            rdata_reg;
  logic [TOTAL_BITS-1:0] fuse_reg;
  logic [E_VIEW_W-1:0]   view_e_reg;
  logic [15:0]           view_d_reg;
  logic                  load_pend_reg;

  logic [3:0]            bank_sel;
  logic [2:0]            cnt_sel;
  logic                  bank_ok;
  logic [8:0]            bank_base;
  logic                  prog_go;
  logic [8:0]            off_a [PROG_BITS];
  logic [8:0]            tgt_a [PROG_BITS];
  logic [PROG_BITS-1:0]  burn_v;
  logic [IDX_W-1:0]      repl_idx;
  logic [E_VIEW_W-1:0]   e_loaded;
  logic                  load_now;
  logic                  view_open;
  logic [3:0]            addr_upper;

  assign bus.rdata = rdata_reg;

  // Host-owned program registers; values are taken as written
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_reg    <= REG_RST;
      cnt_bank_reg <= REG_RST;
      strobe_reg   <= STROBE_OFF;
      data_reg     <= REG_RST;
      access_reg   <= ACCESS_CLOSE;
      reload_reg   <= REG_RST;
      page_reg     <= PAGE_NORMAL;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        REG_START:    start_reg    <= bus.wdata;
        REG_CNT_BANK: cnt_bank_reg <= bus.wdata;
        REG_STROBE:   strobe_reg   <= bus.wdata;
        REG_DATA:     data_reg     <= bus.wdata;
        REG_ACCESS:   access_reg   <= bus.wdata;
        REG_RELOAD:   reload_reg   <= bus.wdata;
        REG_PAGE:     page_reg     <= bus.wdata;
        default:      ;
      endcase
    end
  end

  assign bank_sel = cnt_bank_reg[3:0];
  // at most eight bits per cycle
  assign cnt_sel  = cnt_bank_reg[6:4];
  // only bank values one to five
  assign bank_ok  = (bank_sel >= BANK_FIRST) && (bank_sel <= BANK_E);
  assign bank_base = {bank_sel[2:0] - 3'h1, 6'h00};

  // burn on strobe rise, access open
  assign prog_go = bus.wr && (bus.addr == REG_STROBE) &&
                   (bus.wdata == STROBE_ON) && (strobe_reg != STROBE_ON) &&
                   (access_reg == ACCESS_OPEN) && bank_ok;

  // Data bit k lines up with fuse start plus k
  genvar k;
  generate
    for (k = 0; k < PROG_BITS; k++)
    begin : g_prog
      assign off_a[k]  = {1'b0, start_reg} + 9'(k);
      assign tgt_a[k]  = bank_base + off_a[k];
      // a zero data bit burns the fuse
      assign burn_v[k] = prog_go && (3'(k) <= cnt_sel) &&
                         (off_a[k] < 9'(BANK_BITS)) && !data_reg[k] &&
                         (tgt_a[k] != weak_bit_i);
    end
  endgenerate

  // Reset stands for a blank part; a burned fuse never returns to one
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fuse_reg <= {TOTAL_BITS{1'b1}};
    end
    else
    begin
      for (int i = 0; i < PROG_BITS; i++)
      begin
        if (burn_v[i])
        begin
          fuse_reg[tgt_a[i]] <= 1'b0;
        end
      end
    end
  end

  assign repl_idx = fuse_reg[D_BASE+REPL_MSB:D_BASE+REPL_LSB];

  generate
    for (k = 0; k < E_VIEW_W; k++)
    begin : g_repl
      // one stuck bit forced to zero
      assign e_loaded[k] = fuse_reg[E_BASE+k] &&
                           (repl_idx != 9'(E_BASE + k));
    end
  endgenerate

  assign load_now = load_pend_reg ||
                    (bus.wr && (bus.addr == REG_RELOAD) &&
                     (bus.wdata == RELOAD_CMD));

  // Fuses are copied once after reset release, as a power-up load would
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      load_pend_reg <= 1'b1;
    end
    else
    begin
      load_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      view_e_reg <= {E_VIEW_W{1'b1}};
      view_d_reg <= 16'hFFFF;
    end
    else if (load_now)
    begin
      view_e_reg <= e_loaded;
      view_d_reg <= fuse_reg[D_BASE+REPL_MSB:D_BASE+D_VIEW_LSB];
    end
  end

  // readback only on page three, access open
  assign view_open = (page_reg == PAGE_READ) && (access_reg == ACCESS_OPEN);

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= REG_RST;
    end
    else if (bus.rd)
    begin
      case (bus.addr)
        REG_START:      rdata_reg <= start_reg;
        REG_CNT_BANK:   rdata_reg <= cnt_bank_reg;
        REG_STROBE:     rdata_reg <= strobe_reg;
        REG_DATA:       rdata_reg <= data_reg;
        REG_ACCESS:     rdata_reg <= access_reg;
        REG_RELOAD:     rdata_reg <= reload_reg;
        REG_PAGE:       rdata_reg <= page_reg;
        REG_ADDR_BITS:  rdata_reg <= view_open ? {3'h0, view_e_reg} : REG_RST;
        REG_REPL_UPPER: rdata_reg <= view_open ? view_d_reg[15:8] : REG_RST;
        REG_REPL_LOWER: rdata_reg <= view_open ? view_d_reg[7:0] : REG_RST;
        default:        rdata_reg <= REG_RST;
      endcase
    end
    else
    begin
      rdata_reg <= REG_RST;
    end
  end

  assign addr_upper = view_e_reg[E_ADDR_EN] ? ADDR_DFLT_UPPER
                                            : view_e_reg[3:0];

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      slave_wr_addr_o <= ADDR_DFLT_WR;
      slave_rd_addr_o <= ADDR_DFLT_RD;
    end
    else
    begin
      slave_wr_addr_o <= {addr_upper, ADDR_WR_LOW};
      slave_rd_addr_o <= {addr_upper, ADDR_RD_LOW};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fuse_burn_o <= 1'b0;
    end
    else
    begin
      fuse_burn_o <= (strobe_reg == STROBE_ON) &&
                     (access_reg == ACCESS_OPEN);
    end
  end
endmodule // fuse_program_dev

// ==== fuse_program_host.sv ====
// Host side: sequences program, replacement and verify over the link
`timescale 1ns/1ps
module fuse_program_host
#(
  parameter int PULSE_CYCLES = fuse_pkg::PULSE_CYC_DEF
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  fuse_bus_if.host        bus,
  input  wire logic [3:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  input  wire logic       cmd_wr_i,
  input  wire logic       cmd_rd_i,
  output logic      [7:0] cmd_rdata_o
);
  import fuse_pkg::*;

  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

  typedef enum {SEQ_PROG, SEQ_VERIFY} seq_e;

  logic [7:0]       start_reg;
  logic [7:0]       cb_reg;
  logic [7:0]       data_reg;
  logic [4:0]       expect_reg;
  logic [IDX_W-1:0] idx_reg;
  logic [7:0]       rb27_reg;
  logic [7:0]       rb18_reg;
  logic [7:0]       rb19_reg;
  logic             busy_reg;
  logic             err_reg;
  logic             done_reg;
  logic             rep_reg;
  logic             phase_reg;
  seq_e             seq_reg;
  logic [3:0]       step_reg;
  logic [CNT_W-1:0] wait_reg;
  logic             rd_pend_reg;
  logic [7:0]       rd_addr_reg;
  logic             cmd_go;
  logic [7:0]       p_start;
  logic [7:0]       p_cb;
  logic [7:0]       p_data;
  step_s            st;

  assign cmd_go = cmd_wr_i && (cmd_addr_i == H_CMD) && !busy_reg &&
                  (cmd_wdata_i[1:0] != 2'h0);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_reg  <= REG_RST;
      cb_reg     <= REG_RST;
      data_reg   <= REG_RST;
      expect_reg <= 5'h00;
      idx_reg    <= 9'h000;
    end
    else if (cmd_wr_i)
    begin
      case (cmd_addr_i)
        H_START:  start_reg     <= cmd_wdata_i;
        H_CB:     cb_reg        <= cmd_wdata_i;
        H_DATA:   data_reg      <= cmd_wdata_i;
        H_EXPECT: expect_reg    <= cmd_wdata_i[4:0];
        H_IDX_LO: idx_reg[7:0]  <= cmd_wdata_i;
        H_IDX_HI: idx_reg[8]    <= cmd_wdata_i[0];
        default:  ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_rdata_o <= REG_RST;
    end
    else if (cmd_rd_i)
    begin
      case (cmd_addr_i)
        H_START:  cmd_rdata_o <= start_reg;
        H_CB:     cmd_rdata_o <= cb_reg;
        H_DATA:   cmd_rdata_o <= data_reg;
        H_EXPECT: cmd_rdata_o <= {3'h0, expect_reg};
        H_IDX_LO: cmd_rdata_o <= idx_reg[7:0];
        H_IDX_HI: cmd_rdata_o <= {7'h00, idx_reg[8]};
        H_STATUS: cmd_rdata_o <= {5'h00, done_reg, err_reg, busy_reg};
        H_RB27:   cmd_rdata_o <= rb27_reg;
        H_RB18:   cmd_rdata_o <= rb18_reg;
        H_RB19:   cmd_rdata_o <= rb19_reg;
        default:  cmd_rdata_o <= REG_RST;
      endcase
    end
    else
    begin
      cmd_rdata_o <= REG_RST;
    end
  end

  assign p_start = !rep_reg ? start_reg
                 : (phase_reg ? REPL_HI_START : REPL_LO_START);
  assign p_cb    = !rep_reg ? cb_reg
                 : (phase_reg ? REPL_HI_CB : REPL_LO_CB);
  assign p_data  = !rep_reg ? data_reg
                 : (phase_reg ? {7'h00, idx_reg[8]} : idx_reg[7:0]);

  always_comb
  begin
    st = '{STEP_END, REG_RST, REG_RST};
    if (seq_reg == SEQ_PROG)
    begin
      case (step_reg)
        4'h0: st = '{STEP_WR, REG_ACCESS, ACCESS_OPEN};
        4'h1: st = '{STEP_WR, REG_START, p_start};
        4'h2: st = '{STEP_WR, REG_CNT_BANK, p_cb};
        4'h3: st = '{STEP_WR, REG_DATA, p_data};
        4'h4: st = '{STEP_WR, REG_STROBE, STROBE_ON};
        4'h5: st = '{STEP_WAIT, REG_RST, REG_RST};
        4'h6: st = '{STEP_WR, REG_STROBE, STROBE_OFF};
        4'h7: st = '{STEP_WR, REG_PAGE, PAGE_NORMAL};
        4'h8: st = '{STEP_WR, REG_START, RELOAD_PREP};
        4'h9: st = '{STEP_WR, REG_START, REG_RST};
        4'hA: st = '{STEP_WR, REG_RELOAD, RELOAD_CMD};
        default: st = '{STEP_END, REG_RST, REG_RST};
      endcase
    end
    else
    begin
      case (step_reg)
        4'h0: st = '{STEP_WR, REG_PAGE, PAGE_NORMAL};
        4'h1: st = '{STEP_WR, REG_ACCESS, ACCESS_OPEN};
        4'h2: st = '{STEP_WR, REG_PAGE, PAGE_READ};
        4'h3: st = '{STEP_RD, REG_ADDR_BITS, REG_RST};
        4'h4: st = '{STEP_RD, REG_REPL_UPPER, REG_RST};
        4'h5: st = '{STEP_RD, REG_REPL_LOWER, REG_RST};
        4'h6: st = '{STEP_WR, REG_PAGE, PAGE_NORMAL};
        4'h7: st = '{STEP_WR, REG_ACCESS, ACCESS_CLOSE};
        default: st = '{STEP_END, REG_RST, REG_RST};
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_reg  <= 1'b0;
      err_reg   <= 1'b0;
      done_reg  <= 1'b0;
      rep_reg   <= 1'b0;
      phase_reg <= 1'b0;
      seq_reg   <= SEQ_PROG;
      step_reg  <= 4'h0;
      wait_reg  <= '0;
      bus.addr  <= REG_RST;
      bus.wdata <= REG_RST;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
    end
    else
    begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (!busy_reg)
      begin
        if (cmd_go)
        begin
          busy_reg  <= 1'b1;
          done_reg  <= 1'b0;
          err_reg   <= 1'b0;
          rep_reg   <= cmd_wdata_i[1];
          phase_reg <= 1'b0;
          seq_reg   <= SEQ_PROG;
          step_reg  <= 4'h0;
        end
      end
      else
      begin
        case (st.kind)
          STEP_WR:
          begin
            bus.addr  <= st.addr;
            bus.wdata <= st.data;
            bus.wr    <= 1'b1;
            step_reg  <= step_reg + 4'h1;
          end
          STEP_RD:
          begin
            bus.addr <= st.addr;
            bus.rd   <= 1'b1;
            step_reg <= step_reg + 4'h1;
          end
          STEP_WAIT:
          begin
            if (wait_reg == CNT_W'(PULSE_CYCLES - 1))
            begin
              wait_reg <= '0;
              step_reg <= step_reg + 4'h1;
            end
            else
            begin
              wait_reg <= wait_reg + 1'b1;
            end
          end
          default:
          begin
            step_reg <= 4'h0;
            if ((seq_reg == SEQ_PROG) && rep_reg && !phase_reg)
            begin
              phase_reg <= 1'b1;
            end
            else if (seq_reg == SEQ_PROG)
            begin
              seq_reg <= SEQ_VERIFY;
            end
            else
            begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              err_reg  <= rep_reg ? ((rb18_reg != idx_reg[8:1]) ||
                                     (rb19_reg[7] != idx_reg[0]))
                                  : (rb27_reg[4:0] != expect_reg);
            end
          end
        endcase
      end
    end
  end

  // Read answers arrive one cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= REG_RST;
      rb27_reg    <= REG_RST;
      rb18_reg    <= REG_RST;
      rb19_reg    <= REG_RST;
    end
    else
    begin
      rd_pend_reg <= bus.rd;
      rd_addr_reg <= bus.addr;
      if (rd_pend_reg)
      begin
        case (rd_addr_reg)
          REG_ADDR_BITS:  rb27_reg <= bus.rdata;
          REG_REPL_UPPER: rb18_reg <= bus.rdata;
          REG_REPL_LOWER: rb19_reg <= bus.rdata;
          default:        ;
        endcase
      end
    end
  end
endmodule // fuse_program_host

// ==== fuse_program_slave_addr_monitor.sv ====
// Assertions on the fuse register link and the burn output
`timescale 1ns/1ps
module fuse_program_slave_addr_monitor
#(
  parameter int PULSE_CYCLES = fuse_pkg::PULSE_CYC_DEF
)
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       fuse_burn_o
);
  import fuse_pkg::*;
  localparam int BURN_MAX = PULSE_CYCLES + 8;
  logic [7:0]  acc_reg;
  logic [7:0]  strb_reg;
  logic [15:0] burn_cnt_reg;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Mirrors of the device registers that gate the burn
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_reg  <= ACCESS_CLOSE;
      strb_reg <= STROBE_OFF;
    end
    else if (wr && addr == REG_ACCESS)
      acc_reg <= wdata;
    else if (wr && addr == REG_STROBE)
      strb_reg <= wdata;
  end

  // Length of the current burn, to judge the pulse width
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      burn_cnt_reg <= 16'h0000;
    else if (fuse_burn_o)
      burn_cnt_reg <= burn_cnt_reg + 16'h0001;
    else
      burn_cnt_reg <= 16'h0000;
  end

  sequence s_reload;
    (wr && addr == REG_PAGE && wdata == PAGE_NORMAL)
    ##1 (wr && addr == REG_START && wdata == RELOAD_PREP)
    ##1 (wr && addr == REG_START && wdata == 8'h00)
    ##1 (wr && addr == REG_RELOAD && wdata == RELOAD_CMD);
  endsequence

  sequence s_verify_tail;
    (rd && addr == REG_ADDR_BITS) ##1 (rd && addr == REG_REPL_UPPER)
    ##1 (rd && addr == REG_REPL_LOWER)
    ##1 (wr && addr == REG_PAGE && wdata == PAGE_NORMAL)
    ##1 (wr && addr == REG_ACCESS && wdata == ACCESS_CLOSE);
  endsequence

  a_strobes_apart: assert property (
    !(wr && rd))
    else $error("write and read strobe together");
  a_rdata_idle: assert property (
    !rd |=> rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_burn_gate: assert property (
    fuse_burn_o == ($past(strb_reg) == STROBE_ON
                    && $past(acc_reg) == ACCESS_OPEN))
    else $error("burn does not match strobe and access");
  a_open_first: assert property (
    wr && addr == REG_STROBE && wdata == STROBE_ON |-> acc_reg == ACCESS_OPEN)
    else $error("burn strobe before access opened");
  a_count_bank: assert property (
    wr && addr == REG_CNT_BANK
    |-> !wdata[7] && wdata[3:0] inside {[BANK_FIRST:BANK_E]})
    else $error("bad count or bank field");
  a_pulse_long: assert property (
    $fell(fuse_burn_o) |-> burn_cnt_reg >= 16'(PULSE_CYCLES))
    else $error("burn pulse too short");
  // Counted rather than a delay range: the full-length pulse is far too long
  a_pulse_ends: assert property (
    fuse_burn_o |-> burn_cnt_reg < 16'(BURN_MAX))
    else $error("burn pulse never ends");
  a_reload_next: assert property (
    wr && addr == REG_STROBE && wdata == STROBE_OFF |=> s_reload)
    else $error("reload sequence missing after pulse");
  a_verify_tail: assert property (
    wr && addr == REG_PAGE && wdata == PAGE_READ
    |-> acc_reg == ACCESS_OPEN ##1 s_verify_tail)
    else $error("verify sequence out of order");
  a_repl_low: assert property (
    wr && addr == REG_START && wdata == REPL_LO_START
    |=> wr && addr == REG_CNT_BANK && wdata == REPL_LO_CB)
    else $error("low replacement cycle setup wrong");
  a_repl_high: assert property (
    wr && addr == REG_START && wdata == REPL_HI_START
    |=> wr && addr == REG_CNT_BANK && wdata == REPL_HI_CB)
    else $error("high replacement cycle setup wrong");
endmodule // fuse_program_slave_addr_monitor

// ==== fuse_program_slave_addr_tb.sv ====
// Bench joining the fuse host and sensor ends over their register link
`timescale 1ns/1ps
module fuse_program_slave_addr_tb;
  import fuse_pkg::*;
  localparam int         PULSE = 4;
  localparam logic [8:0] IDX   = 9'(E_BASE + E_ADDR_EN);
  typedef struct packed {
    logic [7:0] start;
    logic [7:0] cb;
    logic [7:0] data;
    logic [4:0] e_bits;
    logic [4:0] rb;
    logic [7:0] wa;
    logic       err;
  } row_s;
  // Rows run in order on one part: burned bits stay burned
  row_s rows [7] = '{
    '{8'h00, 8'h45, 8'h1F, 5'h1F, 5'h1F, 8'h80, 1'h0},
    '{8'h01, 8'h15, 8'h02, 5'h1D, 5'h1D, 8'h80, 1'h0},
    '{8'h04, 8'h05, 8'h00, 5'h0D, 5'h0D, 8'hD0, 1'h0},
    '{8'h00, 8'h45, 8'h1F, 5'h1F, 5'h0D, 8'hD0, 1'h1},
    '{8'h00, 8'h75, 8'hF6, 5'h04, 5'h04, 8'h40, 1'h0},
    '{8'h00, 8'h74, 8'h00, 5'h04, 5'h04, 8'h40, 1'h0},
    '{8'h3C, 8'h75, 8'h00, 5'h04, 5'h04, 8'h40, 1'h0}};
  logic       clk_sys_i;
  logic       rst_i;
  logic [3:0] cmd_addr_i;
  logic [7:0] cmd_wdata_i;
  logic       cmd_wr_i;
  logic       cmd_rd_i;
  logic [7:0] cmd_rdata_o;
  logic [8:0] weak_bit_i;
  logic [7:0] slave_wr_addr_o;
  logic [7:0] slave_rd_addr_o;
  logic       fuse_burn_o;
  logic [7:0] st;
  logic [7:0] v;
  int         num_errors = 0;
  int         cmp_count = 0;

  fuse_bus_if u_fuse_bus_if ();
  fuse_program_host #(.PULSE_CYCLES(PULSE)) u_fuse_program_host (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(u_fuse_bus_if.host),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_rdata_o(cmd_rdata_o));
  fuse_program_dev u_fuse_program_dev (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(u_fuse_bus_if.dev),
    .weak_bit_i(weak_bit_i), .slave_wr_addr_o(slave_wr_addr_o),
    .slave_rd_addr_o(slave_rd_addr_o), .fuse_burn_o(fuse_burn_o));
  fuse_program_slave_addr_monitor #(.PULSE_CYCLES(PULSE))
    u_fuse_program_slave_addr_monitor (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr(u_fuse_bus_if.addr),
    .wdata(u_fuse_bus_if.wdata), .wr(u_fuse_bus_if.wr),
    .rd(u_fuse_bus_if.rd), .rdata(u_fuse_bus_if.rdata),
    .fuse_burn_o(fuse_burn_o));

  always #12.5 clk_sys_i = ~clk_sys_i;

  task automatic check(input string what, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmd_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    cmd_addr_i  <= a;
    cmd_wdata_i <= d;
    cmd_wr_i    <= 1'h1;
    @(posedge clk_sys_i);
    cmd_wr_i <= 1'h0;
  endtask

  task automatic cmd_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    cmd_addr_i <= a;
    cmd_rd_i   <= 1'h1;
    @(posedge clk_sys_i);
    cmd_rd_i <= 1'h0;
    #1;
    d = cmd_rdata_o;
  endtask

  task automatic load_job(input logic [7:0] s, c, d, input logic [4:0] e);
    cmd_wr(H_START, s);
    cmd_wr(H_CB, c);
    cmd_wr(H_DATA, d);
    cmd_wr(H_EXPECT, {3'h0, e});
  endtask

  // A nonzero extra command lands while busy and must be ignored
  task automatic run_cmd(input logic [7:0] c, extra);
    cmd_wr(H_CMD, c);
    if (extra != 8'h00)
      cmd_wr(H_CMD, extra);
    st = 8'h00;
    for (int n = 0; n < 100 && st[2] !== 1'h1; n++)
      cmd_rd(H_STATUS, st);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    summarize();
  end

  initial
  begin
    clk_sys_i   = 1'h0;
    rst_i       = 1'h1;
    cmd_addr_i  = 4'h0;
    cmd_wdata_i = 8'h00;
    cmd_wr_i    = 1'h0;
    cmd_rd_i    = 1'h0;
    weak_bit_i  = 9'h1FF;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    check("wr_addr", ADDR_DFLT_WR, slave_wr_addr_o);
    check("rd_addr", ADDR_DFLT_RD, slave_rd_addr_o);
    foreach (rows[i])
    begin
      load_job(rows[i].start, rows[i].cb, rows[i].data, rows[i].e_bits);
      run_cmd(8'h01, 8'h00);
      check("status", {5'h00, 1'h1, rows[i].err, 1'h0}, st);
      cmd_rd(H_RB27, v);
      check("rb27", {3'h0, rows[i].rb}, {3'h0, v[4:0]});
      check("wr_addr", rows[i].wa, slave_wr_addr_o);
      check("rd_addr", rows[i].wa | 8'h01, slave_rd_addr_o);
    end
    // Fresh blank part whose address enable fuse refuses to burn
    rst_i      <= 1'h1;
    weak_bit_i <= IDX;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    load_job(8'h00, 8'h45, 8'h01, 5'h01);
    run_cmd(8'h01, 8'h02);
    check("status", 8'h06, st);
    check("wr_addr", ADDR_DFLT_WR, slave_wr_addr_o);
    cmd_wr(H_IDX_LO, IDX[7:0]);
    cmd_wr(H_IDX_HI, {7'h00, IDX[8]});
    run_cmd(8'h02, 8'h00);
    check("status", 8'h04, st);
    cmd_rd(H_RB18, v);
    check("rb18", IDX[8:1], v);
    cmd_rd(H_RB19, v);
    check("rb19_msb", {IDX[0], 7'h00}, {v[7], 7'h00});
    cmd_rd(H_RB27, v);
    check("rb27", 8'h01, {3'h0, v[4:0]});
    check("wr_addr", 8'h10, slave_wr_addr_o);
    check("rd_addr", 8'h11, slave_rd_addr_o);
    summarize();
  end
endmodule // fuse_program_slave_addr_tb
